// *** hw/mie_exec.sv ***
// Execute logic for store, option load, idle and return-from-interrupt instructions.
`timescale 1ns/1ps
module mie_exec (
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        reset_n,
  // Instruction issue
  input  wire logic                        instr_valid,
  input  wire logic [mie_pkg::MIE_OPC_W-1:0] instr_word,
  input  wire logic [7:0]                  accumulator,
  input  wire logic [12:0]                 stack_top_value,
  // Register file and stack
  output mie_pkg::mie_fwr_t                file_write,
  output mie_pkg::mie_pcld_t               pc_load,
  output logic [7:0]                       option_reg,
  output logic [7:0]                       interrupt_control_reg,
  output logic                             exec_busy,
  output logic                             exec_done
);
  import mie_pkg::*;

  mie_state_reg_t s_r;
  mie_state_reg_t s_nxt;

  // ==========================================================================
  // Issue timing
  // An instruction is taken at the rising edge where instr_valid is high and the
  // block is not in the second cycle of a return. All results are registered, so
  // the file write, the option and control register updates and the done pulse
  // appear one cycle after the take edge.
  // A return shows its program-counter load, stack pop and busy flag one cycle
  // after the take edge and its done pulse one cycle later. Issue during that busy
  // cycle is dropped without trace; the fetch side owns the refetch and must hold
  // the next instruction until busy falls.
  // Opcodes outside the four handled here are ignored, because the arithmetic
  // decoder beside this block answers them. Keeping this decode narrow means a
  // stray opcode can never produce a file write from this side.
  // Status flags are never touched here, which is why no flag port exists.

  // ==========================================================================
  // Decode
  logic is_store;
  logic is_option;
  logic is_return;
  logic is_idle;

  always_comb begin
    is_store  = instr_word[13:7] == MIE_STORE_PAT;
    is_option = instr_word == MIE_OPTION_OPC;
    is_return = instr_word == MIE_RETURN_OPC;
    is_idle   = (instr_word & MIE_IDLE_MASK) == MIE_IDLE_PAT;
  end

  // ==========================================================================
  // Next state
  always_comb begin
    s_nxt           = s_r;
    s_nxt.fwr.we    = 1'b0;
    s_nxt.pcld.load = 1'b0;
    s_nxt.pcld.pop  = 1'b0;
    s_nxt.done      = 1'b0;
    case (s_r.st)
      MIE_RUN: begin
        if (instr_valid && is_store) begin
          s_nxt.fwr  = '{we: 1'b1, addr: instr_word[6:0], data: accumulator};
          s_nxt.done = 1'b1;
          // The option register shadows its file address for plain stores.
          if (instr_word[6:0] == MIE_OPTION_ADDR) begin
            s_nxt.option = accumulator;
          end else if (instr_word[6:0] == MIE_INTCTL_ADDR) begin
            s_nxt.intctl = accumulator;
          end
        end else if (instr_valid && is_option) begin
          s_nxt.option = accumulator;
          s_nxt.done   = 1'b1;
        end else if (instr_valid && is_return) begin
          s_nxt.pcld   = '{load: 1'b1, pop: 1'b1, pc: stack_top_value};
          s_nxt.intctl[MIE_GATE_BIT] = 1'b1;
          s_nxt.st     = MIE_RET2;
          s_nxt.busy   = 1'b1;
        end else if (instr_valid && is_idle) begin
          s_nxt.done = 1'b1;
        end
      end
      MIE_RET2: begin
        // Second cycle is the refetch slot; issue is ignored here.
        s_nxt.st   = MIE_RUN;
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end
      default: s_nxt.st = MIE_RUN;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_r        <= '0;
      s_r.st     <= MIE_RUN;
      s_r.option <= MIE_OPTION_RST;
      s_r.intctl <= MIE_INTCTL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign file_write            = s_r.fwr;
  assign pc_load               = s_r.pcld;
  assign option_reg            = s_r.option;
  assign interrupt_control_reg = s_r.intctl;
  assign exec_busy             = s_r.busy;
  assign exec_done             = s_r.done;

  // ==========================================================================
  // Checks
  a_store_writes: assert property (@(posedge clock) disable iff (!reset_n)
    (s_r.st == MIE_RUN && instr_valid && is_store) |=>
      (file_write.we && file_write.addr == $past(instr_word[6:0])
       && file_write.data == $past(accumulator) && exec_done))
    else $error("store did not write file register");
  a_option_load: assert property (@(posedge clock) disable iff (!reset_n)
    (s_r.st == MIE_RUN && instr_valid && is_option) |=> option_reg == $past(accumulator))
    else $error("option load missed");
  a_option_alias: assert property (@(posedge clock) disable iff (!reset_n)
    (s_r.st == MIE_RUN && instr_valid && is_store && instr_word[6:0] == MIE_OPTION_ADDR)
      |=> option_reg == $past(accumulator))
    else $error("option not reached by store");
  a_return_pc: assert property (@(posedge clock) disable iff (!reset_n)
    (s_r.st == MIE_RUN && instr_valid && is_return) |=>
      (pc_load.load && pc_load.pop && pc_load.pc == $past(stack_top_value)))
    else $error("return did not load pc");
  a_return_gate: assert property (@(posedge clock) disable iff (!reset_n)
    (s_r.st == MIE_RUN && instr_valid && is_return) |=> interrupt_control_reg[MIE_GATE_BIT])
    else $error("gate not set on return");
  a_return_two: assert property (@(posedge clock) disable iff (!reset_n)
    (s_r.st == MIE_RUN && instr_valid && is_return) |=> (exec_busy && !exec_done) ##1
      (!exec_busy && exec_done))
    else $error("return not two cycles");
  a_idle_quiet: assert property (@(posedge clock) disable iff (!reset_n)
    (s_r.st == MIE_RUN && instr_valid && is_idle) |=>
      (!file_write.we && !pc_load.load && exec_done && $stable(option_reg)
       && $stable(interrupt_control_reg)))
    else $error("idle changed state");
  a_single_cycle: assert property (@(posedge clock) disable iff (!reset_n)
    (s_r.st == MIE_RUN && instr_valid && (is_store || is_option)) |=> !exec_busy)
    else $error("single cycle op stalled");

  // ==========================================================================
  // Checks on side effects and refused issue
  // A single-cycle instruction must never leave a trace on the program counter,
  // since the fetch side would then jump without a return in flight.
  a_store_no_pc: assert property (@(posedge clock) disable iff (!reset_n)
    (s_r.st == MIE_RUN && instr_valid && is_store) |=>
      (!pc_load.load && !pc_load.pop && !exec_busy))
    else $error("store touched the program counter");

  a_intctl_alias: assert property (@(posedge clock) disable iff (!reset_n)
    (s_r.st == MIE_RUN && instr_valid && is_store && instr_word[6:0] == MIE_INTCTL_ADDR)
      |=> interrupt_control_reg == $past(accumulator))
    else $error("store missed the control register copy");

  a_store_keeps_opt: assert property (@(posedge clock) disable iff (!reset_n)
    (s_r.st == MIE_RUN && instr_valid && is_store && instr_word[6:0] != MIE_OPTION_ADDR)
      |=> $stable(option_reg))
    else $error("store to another address changed option");

  a_option_no_write: assert property (@(posedge clock) disable iff (!reset_n)
    (s_r.st == MIE_RUN && instr_valid && is_option) |=>
      (!file_write.we && !pc_load.load && exec_done && $stable(interrupt_control_reg)))
    else $error("option load had side effects");

  a_return_no_write: assert property (@(posedge clock) disable iff (!reset_n)
    (s_r.st == MIE_RUN && instr_valid && is_return) |=>
      (!file_write.we && $stable(option_reg)))
    else $error("return wrote a register");

  a_pop_with_load: assert property (@(posedge clock) disable iff (!reset_n)
    pc_load.pop == pc_load.load)
    else $error("stack pop and pc load split");

  a_pop_one_shot: assert property (@(posedge clock) disable iff (!reset_n)
    pc_load.pop |=> !pc_load.pop)
    else $error("stack popped twice");

  a_load_from_return: assert property (@(posedge clock) disable iff (!reset_n)
    pc_load.load |-> (exec_busy && $past(instr_valid) && $past(is_return)))
    else $error("pc load without return");

  a_return_gate_only: assert property (@(posedge clock) disable iff (!reset_n)
    (s_r.st == MIE_RUN && instr_valid && is_return) |=>
      (interrupt_control_reg[6:0] == $past(interrupt_control_reg[6:0])))
    else $error("return changed other control bits");

  a_gate_kept: assert property (@(posedge clock) disable iff (!reset_n)
    exec_busy |-> interrupt_control_reg[MIE_GATE_BIT])
    else $error("gate clear during return");

  // The busy cycle is the refetch slot; anything issued there must vanish.
  a_busy_ends: assert property (@(posedge clock) disable iff (!reset_n)
    exec_busy |=> (!exec_busy && exec_done))
    else $error("busy lasted too long");

  a_busy_refuses: assert property (@(posedge clock) disable iff (!reset_n)
    exec_busy |=> (!file_write.we && !pc_load.load && $stable(option_reg)
      && $stable(interrupt_control_reg)))
    else $error("issue taken while busy");

  a_idle_no_busy: assert property (@(posedge clock) disable iff (!reset_n)
    (s_r.st == MIE_RUN && instr_valid && is_idle) |=> (!exec_busy && !pc_load.pop))
    else $error("idle stalled or popped");
endmodule

// *** hw/mie_pkg.sv ***
// Package for the miscellaneous instruction execute block.
package mie_pkg;

  // ==========================================================================
  // Widths and encodings
  localparam int          MIE_OPC_W        = 14;
  localparam int          MIE_PC_W         = 13;
  localparam int          MIE_DATA_W       = 8;
  localparam int          MIE_FADDR_W      = 7;
  localparam logic [6:0]  MIE_STORE_PAT    = 7'h01;    // Upper seven bits 00 0000 1.
  localparam logic [13:0] MIE_OPTION_OPC   = 14'h0062;
  localparam logic [13:0] MIE_RETURN_OPC   = 14'h0009;
  localparam logic [13:0] MIE_IDLE_MASK    = 14'h3f9f; // Bits 6:5 are don't care.
  localparam logic [13:0] MIE_IDLE_PAT     = 14'h0000;
  localparam logic [6:0]  MIE_OPTION_ADDR  = 7'h01;    // Option register as a file address.
  localparam logic [6:0]  MIE_INTCTL_ADDR  = 7'h0b;
  localparam int          MIE_GATE_BIT     = 7;
  localparam logic [7:0]  MIE_OPTION_RST   = 8'hff;
  localparam logic [7:0]  MIE_INTCTL_RST   = 8'h00;

  typedef enum logic [1:0] {MIE_RUN, MIE_RET2} mie_state_t;

  // Register-file write request.
  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] data;
  } mie_fwr_t;

  // Program-counter load with stack pop.
  typedef struct packed {
    logic        load;
    logic        pop;
    logic [12:0] pc;
  } mie_pcld_t;

  typedef struct packed {
    mie_state_t  st;
    mie_fwr_t    fwr;
    mie_pcld_t   pcld;
    logic [7:0]  option;
    logic [7:0]  intctl;
    logic        busy;
    logic        done;
  } mie_state_reg_t;

endpackage

// *** dv/mie_exec_tb.sv ***
// Self-checking testbench for the miscellaneous instruction execute block.
`timescale 1ns/1ps
module mie_exec_tb;
  import mie_pkg::*;
  typedef struct packed {int due; logic [46:0] val; logic [46:0] msk;} mie_note_t;
  logic clock, reset_n, instr_valid, exec_busy, exec_done;
  logic [13:0] instr_word;
  logic [7:0]  accumulator, option_reg, interrupt_control_reg, opt_m, ic_m;
  logic [12:0] stack_top_value;
  logic [6:0]  addr;
  mie_fwr_t    file_write, fw_l;
  mie_pcld_t   pc_load, pc_l;
  mie_note_t   q[$];
  mie_note_t   n;
  int          err_count, tests_run, seed = 12;
  int          cyc = 0;
  localparam logic [46:0] ALL = '1;
  localparam logic [46:0] NFW = {16'h0, {31{1'b1}}};
  mie_exec u_mie_exec (.clock(clock), .reset_n(reset_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .accumulator(accumulator), .stack_top_value(stack_top_value),
    .file_write(file_write), .pc_load(pc_load), .option_reg(option_reg),
    .interrupt_control_reg(interrupt_control_reg), .exec_busy(exec_busy),
    .exec_done(exec_done));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic check(input logic [46:0] got, input logic [46:0] exp, input logic [46:0] m,
                       input int c, input int due);
    tests_run++;
    if ((got & m) !== (exp & m) || c != due) begin
      $display("BAD t=%0t got=%h exp=%h cyc=%h due=%h", $time, got, exp, c, due);
      err_count++;
    end
  endtask
  task automatic wrap_up();
    $display("tests_run=%0d err_count=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Each note is due a fixed number of edges after the take edge.
  task automatic issue(input logic [13:0] op, input int lat, input logic [46:0] v,
                       input logic [46:0] m);
    instr_valid = 1'b1;
    instr_word  = op;
    q.push_back('{cyc + lat, v, m});
    @(negedge clock);
  endtask
  task automatic store(input logic [6:0] a, input logic [7:0] d);
    accumulator = d;
    if (a == 7'h01) opt_m = d;
    if (a == 7'h0b) ic_m = d;
    issue({7'h01, a}, 1, {1'b1, a, d, 15'h0, opt_m, ic_m}, ALL);
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc > 2000) begin
      err_count++;
      wrap_up();
    end
  end
  // Pulses are latched until the matching done so that a pc load one cycle ahead of its done still lines up.
  always @(negedge clock) begin
    if (file_write.we) fw_l = file_write;
    if (pc_load.load) pc_l = pc_load;
    if (exec_done) begin
      n = (q.size() > 0) ? q.pop_front() : '{0, '0, '0};
      check({fw_l, pc_l, option_reg, interrupt_control_reg}, n.val, n.msk, cyc, n.due);
      fw_l = '0;
      pc_l = '0;
    end
  end
  initial begin
    {reset_n, instr_valid, instr_word, accumulator, stack_top_value} = '0;
    {fw_l, pc_l} = '0;
    repeat (5) @(negedge clock);
    check({option_reg, interrupt_control_reg}, 47'hff00, ALL, 0, 0);
    reset_n = 1'b1;
    {opt_m, ic_m} = 16'hff00;
    @(negedge clock);
    for (int i = 0; i < 12; i++) begin
      addr = (i == 0) ? 7'h01 : (i == 1) ? 7'h0b : 7'($random(seed));
      store(addr, 8'($random(seed)));
    end
    $display("store test done");
    for (int i = 0; i < 3; i++) begin
      accumulator = 8'($random(seed));
      opt_m = accumulator;
      issue(14'h0062, 1, {31'h0, opt_m, ic_m}, NFW);
    end
    $display("option test done");
    for (int k = 0; k < 4; k++) begin
      accumulator = 8'($random(seed));
      issue({7'h0, 2'(k), 5'h0}, 1, {31'h0, opt_m, ic_m}, ALL);
    end
    $display("idle test done");
    for (int i = 0; i < 2; i++) begin
      store(7'h0b, 8'($random(seed)) & 8'h7f);
      stack_top_value = 13'($random(seed));
      ic_m[7] = 1'b1;
      issue(14'h0009, 2, {16'h0, 2'b11, stack_top_value, opt_m, ic_m}, NFW);
      instr_word  = {7'h01, 7'h0b};
      accumulator = 8'h00;
      @(negedge clock);
    end
    instr_valid = 1'b0;
    repeat (4) @(negedge clock);
    $display("return test done");
    if (q.size() != 0) err_count++;
    wrap_up();
  end
endmodule
